// file: bench/flash_program_mode_entry_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_program_mode_entry_tb;
	import fpme_pkg::*;
	logic        clk, rst_n, msel, strap, rxd, sclk, preq, blank, intact;
	logic        txd, txoe, busy, pdone, perr, freq, fack, pmode, smode, amode;
	logic        idok, btouch, txbusy, bz, t;
	logic [1:0]  pop, fop;
	logic [15:0] paddr, faddr;
	logic [7:0]  pwd, prd, frd, fwd, d, rb;
	logic [9:0]  pq[$];
	logic [7:0]  tq[$], sq[$];
	int          fail_count, n_checks, nreq, k;
	// shared pin: strap level unless the device drives it
	wire         pin45 = txoe ? txd : strap;

	fpme_top fpme_top_i (.ref_clk_i(clk), .arst_n_i(rst_n), .mode_select_pin_i(msel),
		.boot_entry_pin_i(pin45), .serial_receive_port_bit_i(rxd),
		.serial_clock_port_bit_i(sclk), .serial_transmit_port_bit_o(txd),
		.serial_transmit_port_bit_oe_o(txoe), .busy_port_bit_o(busy), .par_req_i(preq),
		.par_op_i(pop), .par_addr_i(paddr), .par_wdata_i(pwd), .par_done_o(pdone),
		.par_err_o(perr), .par_rdata_o(prd), .flash_blank_i(blank),
		.flash_boot_intact_i(intact), .flash_ack_i(fack), .flash_rdata_i(frd),
		.flash_req_o(freq), .flash_op_o(fop), .flash_addr_o(faddr), .flash_wdata_o(fwd),
		.par_mode_o(pmode), .ser_mode_o(smode), .async_mode_o(amode), .id_ok_o(idok),
		.boot_touched_o(btouch));
	fpme_flash_model fpme_flash_model_i (.ref_clk_i(clk), .arst_n_i(rst_n), .req_i(freq),
		.op_i(fop), .addr_i(faddr), .wdata_i(fwd), .ack_o(fack), .rdata_o(frd));

	initial
	begin
		clk = 1'b0;
		forever
			#12.5 clk = ~clk;
	end

	// ****************
	// shared tasks
	// ****************
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic guard(input int i);
		if (i > 5000)
		begin
			fail_count++;
			test_done;
		end
	endtask
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8];
	endfunction
	task automatic do_reset(input logic m, input logic s, input logic c, input logic b);
		rst_n = 1'b0;
		msel = m;
		strap = s;
		rxd = 1'b1;
		sclk = c;
		intact = b;
		tick(16);
		rst_n = 1'b1;
		tick(10);
	endtask
	task automatic send_byte(input logic [7:0] b);
		if (amode)
		begin
			rxd = 1'b0;
			tick(40);
			for (int i = 0; i < 9; i++)
			begin
				rxd = (i < 8) ? b[i] : 1'b1;
				tick(40);
			end
		end
		else
		begin
			for (int i = 0; i < 8; i++)
			begin
				sclk = 1'b0;
				rxd = b[i];
				#100;
				sclk = 1'b1;
				#100;
			end
			rxd = ~b[7];
			tick(8);
		end
	endtask
	// sends the whole command, then waits until busy and the reply are over
	task automatic send_q;
		foreach (sq[i])
			send_byte(sq[i]);
		sq.delete();
		bz = 1'b0;
		for (int i = 0; i < 12; i++)
		begin
			bz = bz | (busy === 1'b1);
			tick(1);
		end
		// clocked variant: the programmer clocks the reply out, receive held low
		if (amode === 1'b0 && tq.size() > 0)
		begin
			rxd = 1'b0;
			tick(30);
			for (int i = 0; i < 8; i++)
			begin
				rb[i] = pin45;
				sclk = 1'b0;
				#100;
				sclk = 1'b1;
				#100;
			end
			chk("sync tx byte", rb, tq.pop_front());
		end
		for (int i = 0; busy !== 1'b0 || txbusy; i++)
		begin
			guard(i);
			tick(1);
		end
		tick(4);
	endtask
	task automatic push_id(input logic [7:0] x);
		sq.push_back(CMD_ID);
		for (int i = 0; i < ID_LEN; i++)
			sq.push_back(pat(ID_FIRST + 16'(i)) ^ x);
		send_q;
	endtask
	task automatic par(input logic [1:0] op, input logic [15:0] a, input logic [15:0] fa,
		input logic [9:0] note);
		pop = op;
		paddr = a;
		pq.push_back(note);
		preq = 1'b1;
		for (int i = 0; pdone !== 1'b1; i++)
		begin
			if (freq === 1'b1)
				chk("flash addr", faddr, fa);
			guard(i);
			tick(1);
		end
		preq = 1'b0;
		tick(1);
	endtask

	// ****************
	// result monitors
	// ****************
	always @(posedge freq)
		nreq++;
	always @(negedge clk)
		if (pdone === 1'b1)
		begin
			chk("par err", perr, pq[0][8]);
			if (pq[0][9])
				chk("par rdata", prd, pq[0][7:0]);
			pq.pop_front();
		end
	always @(negedge clk)
		if (amode === 1'b1 && txoe === 1'b1 && pin45 === 1'b0 && !txbusy)
		begin : rx_frame
			logic [7:0] v;
			txbusy = 1'b1;
			tick(20);
			for (int i = 0; i < 8; i++)
			begin
				tick(40);
				v[i] = pin45;
			end
			tick(40);
			chk("stop bit", pin45, 1'b1);
			chk("tx byte", v, tq.size() > 0 ? tq.pop_front() : 8'hxx);
			txbusy = 1'b0;
		end

	// ****************
	// main sequence
	// ****************
	initial
	begin
		rst_n = 1'b0;
		{msel, strap, sclk, preq, blank, txbusy} = 6'h0;
		{rxd, intact} = 2'h3;
		{pop, paddr, pwd} = 26'h0;
		{fail_count, n_checks, nreq} = 96'h0;
		void'($urandom(32'hc76f0e7f));
		do_reset(1'b1, 1'b1, 1'b1, 1'b1);
		chk("ser mode", smode, 1'b1);
		chk("async", amode, 1'b0);
		chk("tx enable", txoe, 1'b1);
		push_id(8'h00);
		chk("id ok", idok, 1'b1);
		tq.push_back(pat(16'h0102));
		sq = '{CMD_READ, 8'h01, 8'h02};
		send_q;
		$display("test sync id done");
		do_reset(1'b1, 1'b1, 1'b0, 1'b1);
		chk("async", amode, 1'b1);
		blank = 1'b1;
		k = nreq;
		tq.push_back(pat(16'h0304));
		sq = '{CMD_READ, 8'h03, 8'h04};
		send_q;
		chk("blank open", 16'(nreq), 16'(k + 1));
		blank = 1'b0;
		k = nreq;
		sq = '{CMD_READ, 8'h01, 8'h02};
		send_q;
		chk("locked req", 16'(nreq), 16'(k));
		push_id(8'h01);
		chk("id bad", idok, 1'b0);
		push_id(8'h00);
		chk("id ok", idok, 1'b1);
		tq.push_back(pat(16'h0102));
		sq = '{CMD_READ, 8'h01, 8'h02};
		send_q;
		chk("busy", bz, 1'b1);
		k = nreq;
		sq = '{CMD_PROG, 8'hf0, 8'h10, 8'h55};
		send_q;
		sq = '{CMD_ERASE, 8'hff, 8'hff};
		send_q;
		chk("boot write", 16'(nreq), 16'(k));
		sq = '{CMD_ERASE, 8'h01, 8'h00};
		send_q;
		chk("user erase", 16'(nreq), 16'(k + 1));
		d = 8'($urandom);
		sq = '{CMD_PROG, 8'h02, 8'h00, d};
		send_q;
		tq.push_back(d);
		sq = '{CMD_READ, 8'h02, 8'h00};
		send_q;
		chk("replies", 16'(tq.size()), 16'h0);
		$display("test async serial done");
		do_reset(1'b1, 1'b0, 1'b0, 1'b1);
		chk("par mode", pmode, 1'b1);
		d = 8'($urandom);
		pwd = d;
		par(OP_PROG, 16'h1234, 16'h1234, 10'h000);
		par(OP_READ, 16'h1234, 16'h1234, {2'b10, d});
		pwd = ~d;
		par(OP_PROG, 16'hf777, 16'hf777, 10'h000);
		par(OP_READ, 16'hf777, 16'hf777, {2'b10, ~d});
		par(OP_ERASE, 16'hf123, 16'hffff, 10'h000);
		par(OP_READ, 16'hf000, 16'hf000, 10'h2ff);
		par(OP_READ, 16'hefff, 16'hefff, {2'b10, pat(16'hefff)});
		par(OP_BAD, 16'h0000, 16'h0000, 10'h100);
		t = btouch;
		chk("boot touched", t, 1'b1);
		$display("test parallel done");
		do_reset(1'b1, 1'b1, 1'b0, ~t);
		chk("ser blocked", smode, 1'b0);
		do_reset(1'b0, 1'b1, 1'b0, 1'b1);
		chk("normal par", pmode, 1'b0);
		chk("normal ser", smode, 1'b0);
		$display("test mode straps done");
		test_done;
	end
endmodule
`default_nettype wire

// file: bench/fpme_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpme_flash_model
(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        arst_n_i,
	// request side
	input  wire logic        req_i,
	input  wire logic [1:0]  op_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	output var  logic        ack_o,
	output var  logic [7:0]  rdata_o
);
	import fpme_pkg::*;
	logic [7:0] mem [0:65535];
	logic [2:0] wait_cnt;
	// contents survive reset, as a real array does
	initial
	begin
		for (int a = 0; a < 65536; a++)
			mem[a] = 8'(a) ^ 8'(a >> 8);
	end
	// latency of 1 to 4 cycles, taken from the low address bits
	always @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ack_o <= 1'b0;
			wait_cnt <= 3'h0;
			rdata_o <= 8'h5a;
		end
		else if (req_i && !ack_o && wait_cnt == {1'b0, addr_i[1:0]})
		begin
			ack_o <= 1'b1;
			wait_cnt <= 3'h0;
			rdata_o <= mem[addr_i];
			if (op_i == OP_PROG)
				mem[addr_i] <= wdata_i;
			if (op_i == OP_ERASE && addr_i >= BOOT_START)
				for (int a = 16'hf000; a < 65536; a++)
					mem[a] <= 8'hff;
		end
		else
		begin
			ack_o <= 1'b0;
			// stale data never holds between answers
			rdata_o <= ~rdata_o;
			if (req_i && !ack_o)
				wait_cnt <= wait_cnt + 3'h1;
		end
	end
endmodule
`default_nettype wire

// file: common/fpme_pkg.sv
`default_nettype none
package fpme_pkg;

	// ***************************************
	// clock and link timing
	// ***************************************
	localparam int unsigned CLK_HZ         = 40_000_000;
	localparam int unsigned BIT_TIME_NS    = 1000;
	localparam int unsigned BIT_CYCLES_INT = (CLK_HZ / 1_000_000) * BIT_TIME_NS / 1000;
	localparam logic [5:0]  BIT_CYCLES     = 6'(BIT_CYCLES_INT);
	localparam logic [5:0]  BIT_HALF       = 6'(BIT_CYCLES_INT / 2);
	localparam logic [3:0]  LAST_BIT_SYNC  = 4'h7;
	localparam logic [3:0]  LAST_BIT_ASYNC = 4'h9;
	localparam int unsigned RESET_MIN_OSC  = 16;
	localparam logic [2:0]  SETTLE_CYCLES  = 3'h6;

	// ***************************************
	// flash map
	// ***************************************
	localparam int          ADDR_W     = 16;
	localparam logic [15:0] BOOT_START = 16'hf000;
	localparam logic [15:0] BOOT_END   = 16'hffff;
	localparam logic [15:0] ID_FIRST   = 16'hffd4;
	localparam logic [15:0] ID_LAST    = 16'hffda;
	localparam int          ID_LEN     = 7;
	localparam logic [2:0]  ID_LAST_IX = 3'h6;

	// ***************************************
	// flash operations
	// ***************************************
	localparam logic [1:0] OP_READ  = 2'h0;
	localparam logic [1:0] OP_PROG  = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h2;
	localparam logic [1:0] OP_BAD   = 2'h3;

	// ***************************************
	// serial commands and argument counts
	// ***************************************
	localparam logic [7:0] CMD_ID    = 8'hf5;
	localparam logic [7:0] CMD_READ  = 8'hff;
	localparam logic [7:0] CMD_PROG  = 8'h41;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [2:0] ARGS_ID   = 3'h7;
	localparam logic [2:0] ARGS_PROG = 3'h3;
	localparam logic [2:0] ARGS_ADDR = 3'h2;

endpackage
`default_nettype wire

// file: rtl/fpme_serial.sv
`timescale 1ns/1ps
`default_nettype none
module fpme_serial
(
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       arst_n_i,
	// mode
	input  wire logic       enable_i,
	input  wire logic       async_mode_i,
	// pins
	input  wire logic       rxd_i,
	input  wire logic       sclk_i,
	output var  logic       txd_o,
	// byte side
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_byte_i,
	output var  logic       tx_done_o,
	output var  logic       rx_valid_o,
	output var  logic [7:0] rx_byte_o
);
	import fpme_pkg::*;

	logic       rx_s;
	logic       sclk_s;
	logic       sclk_d;
	logic [7:0] rx_sh;
	logic [3:0] rx_bits;
	logic [5:0] rx_cnt;
	logic       rx_run;
	logic [9:0] tx_sh;
	logic [3:0] tx_bits;
	logic [5:0] tx_cnt;
	logic       tx_run;

	fpme_sync #(.RST_VAL(1'b1)) u_rx_sync
	(
		.ref_clk_i(ref_clk_i),
		.arst_n_i (arst_n_i),
		.d_i      (rxd_i),
		.q_o      (rx_s)
	);

	fpme_sync #(.RST_VAL(1'b1)) u_clk_sync
	(
		.ref_clk_i(ref_clk_i),
		.arst_n_i (arst_n_i),
		.d_i      (sclk_i),
		.q_o      (sclk_s)
	);

	wire       sclk_rise = sclk_s & ~sclk_d;
	wire       sclk_fall = ~sclk_s & sclk_d;
	wire       rx_tick   = (rx_cnt == BIT_CYCLES - 6'h01);
	wire       tx_tick   = (tx_cnt == BIT_CYCLES - 6'h01);
	wire       tx_step   = async_mode_i ? tx_tick : sclk_fall;
	wire [3:0] tx_last   = async_mode_i ? LAST_BIT_ASYNC : LAST_BIT_SYNC;
	wire [9:0] tx_frame  = async_mode_i ? {1'b1, tx_byte_i, 1'b0} : {2'b11, tx_byte_i};
	wire [7:0] rx_next   = {rx_s, rx_sh[7:1]};

	// ***************************************
	// receiver: clocked variant samples on rising clock, async variant mid-bit
	// ***************************************
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sclk_d <= 1'b1;
			rx_sh <= 8'h00;
			rx_bits <= 4'h0;
			rx_cnt <= 6'h00;
			rx_run <= 1'b0;
			rx_valid_o <= 1'b0;
			rx_byte_o <= 8'h00;
		end
		else
		begin
			sclk_d <= sclk_s;
			rx_valid_o <= 1'b0;
			if (!enable_i)
			begin
				rx_run <= 1'b0;
				rx_bits <= 4'h0;
			end
			else if (!async_mode_i)
			begin
				if (sclk_rise)
				begin
					rx_sh <= rx_next;
					rx_bits <= (rx_bits == LAST_BIT_SYNC) ? 4'h0 : rx_bits + 4'h1;
					rx_valid_o <= (rx_bits == LAST_BIT_SYNC);
					rx_byte_o <= rx_next;
				end
			end
			else if (!rx_run)
			begin
				rx_run <= ~rx_s;
				rx_cnt <= BIT_HALF;
				rx_bits <= 4'h0;
			end
			else if (rx_tick)
			begin
				rx_cnt <= 6'h00;
				rx_bits <= rx_bits + 4'h1;
				if (rx_bits == 4'h0)
					rx_run <= ~rx_s;
				else if (rx_bits == LAST_BIT_ASYNC)
				begin
					rx_run <= 1'b0;
					rx_valid_o <= rx_s;
					rx_byte_o <= rx_sh;
				end
				else
					rx_sh <= rx_next;
			end
			else
				rx_cnt <= rx_cnt + 6'h01;
		end
	end

	// ***************************************
	// transmitter: clocked variant shifts on falling clock, async at bit rate
	// ***************************************
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			tx_sh <= 10'h3ff;
			tx_bits <= 4'h0;
			tx_cnt <= 6'h00;
			tx_run <= 1'b0;
			txd_o <= 1'b1;
			tx_done_o <= 1'b0;
		end
		else
		begin
			tx_done_o <= 1'b0;
			if (!enable_i)
			begin
				tx_run <= 1'b0;
				txd_o <= 1'b1;
			end
			else if (!tx_run)
			begin
				if (tx_valid_i)
				begin
					tx_run <= 1'b1;
					tx_sh <= tx_frame;
					txd_o <= tx_frame[0];
					tx_bits <= 4'h0;
					tx_cnt <= 6'h00;
				end
			end
			else
			begin
				tx_cnt <= tx_tick ? 6'h00 : tx_cnt + 6'h01;
				if (tx_step && tx_bits == tx_last)
				begin
					tx_run <= 1'b0;
					tx_done_o <= 1'b1;
					txd_o <= 1'b1;
				end
				else if (tx_step)
				begin
					tx_sh <= {1'b1, tx_sh[9:1]};
					txd_o <= tx_sh[1];
					tx_bits <= tx_bits + 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/fpme_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fpme_sync
#(
	parameter logic RST_VAL = 1'b0
)
(
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic arst_n_i,
	// raw pin and settled level
	input  wire logic d_i,
	output var  logic q_o
);
	logic s1;
	logic s2;
	logic s3;

	// a change counts once the second and third stages agree
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			q_o <= RST_VAL;
		end
		else
		begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				q_o <= s3;
		end
	end
endmodule
`default_nettype wire

// file: rtl/fpme_top.sv
// Functional notes
// - parallel mode takes commands, address and data to read, program, erase flash
// - parallel mode rewrites user and boot areas with identical operations
// - boot area is 4 Kbyte at f000 through ffff
// - boot block erase clears the whole 4 Kbyte area as one block
// - serial mode entered when reset releases with both straps high
// - serial mode rewrites flash through the boot control program, not bus cycles
// - serial mode unusable once the boot area has been rewritten
// - serial mode rewrites user area only, boot writes refused
// - serial mode has a clocked variant 1 and an async variant 2
// - serial uses receive, transmit, clock input and busy output pins
// - serial mode uses a 7-byte id code compared with the sent code
// - non-blank flash rejects commands until the id code matches
// - stored id bytes read from ffd4 through ffda
`timescale 1ns/1ps
`default_nettype none
module fpme_top
(
	// clock and reset
	input  wire logic                       ref_clk_i,
	input  wire logic                       arst_n_i,
	// mode straps
	input  wire logic                       mode_select_pin_i,
	input  wire logic                       boot_entry_pin_i,
	// serial pins
	input  wire logic                       serial_receive_port_bit_i,
	input  wire logic                       serial_clock_port_bit_i,
	output var  logic                       serial_transmit_port_bit_o,
	output var  logic                       serial_transmit_port_bit_oe_o,
	output var  logic                       busy_port_bit_o,
	// parallel writer port
	input  wire logic                       par_req_i,
	input  wire logic [1:0]                 par_op_i,
	input  wire logic [fpme_pkg::ADDR_W-1:0] par_addr_i,
	input  wire logic [7:0]                 par_wdata_i,
	output var  logic                       par_done_o,
	output var  logic                       par_err_o,
	output var  logic [7:0]                 par_rdata_o,
	// flash array port
	input  wire logic                       flash_blank_i,
	input  wire logic                       flash_boot_intact_i,
	input  wire logic                       flash_ack_i,
	input  wire logic [7:0]                 flash_rdata_i,
	output var  logic                       flash_req_o,
	output var  logic [1:0]                 flash_op_o,
	output var  logic [fpme_pkg::ADDR_W-1:0] flash_addr_o,
	output var  logic [7:0]                 flash_wdata_o,
	// status
	output var  logic                       par_mode_o,
	output var  logic                       ser_mode_o,
	output var  logic                       async_mode_o,
	output var  logic                       id_ok_o,
	output var  logic                       boot_touched_o
);
	import fpme_pkg::*;

	typedef enum logic [3:0] {ST_SETTLE, ST_IDLE, ST_PAR_FLASH, ST_CMD, ST_ARG, ST_EXEC,
		ST_IDREAD, ST_SER_FLASH, ST_SEND} fpme_state_e;

	fpme_state_e state;
	logic [2:0]  settle_cnt;
	logic        mode_sel_s;
	logic        boot_ent_s;
	logic        sclk_s;
	logic [7:0]  cmd;
	logic [7:0]  arg [0:ID_LEN-1];
	logic [2:0]  arg_cnt;
	logic [2:0]  id_idx;
	logic        id_miss;
	logic        tx_valid;
	logic [7:0]  tx_byte;
	logic        tx_done;
	logic        rx_valid;
	logic [7:0]  rx_byte;

	// ***************************************
	// strap and clock-level synchronisers
	// ***************************************
	fpme_sync #(.RST_VAL(1'b0)) u_mode_sync
	(
		.ref_clk_i(ref_clk_i),
		.arst_n_i (arst_n_i),
		.d_i      (mode_select_pin_i),
		.q_o      (mode_sel_s)
	);

	fpme_sync #(.RST_VAL(1'b0)) u_boot_sync
	(
		.ref_clk_i(ref_clk_i),
		.arst_n_i (arst_n_i),
		.d_i      (boot_entry_pin_i),
		.q_o      (boot_ent_s)
	);

	fpme_sync #(.RST_VAL(1'b1)) u_sclk_sync
	(
		.ref_clk_i(ref_clk_i),
		.arst_n_i (arst_n_i),
		.d_i      (serial_clock_port_bit_i),
		.q_o      (sclk_s)
	);

	fpme_serial u_serial
	(
		.ref_clk_i   (ref_clk_i),
		.arst_n_i    (arst_n_i),
		.enable_i    (ser_mode_o),
		.async_mode_i(async_mode_o),
		.rxd_i       (serial_receive_port_bit_i),
		.sclk_i      (serial_clock_port_bit_i),
		.txd_o       (serial_transmit_port_bit_o),
		.tx_valid_i  (tx_valid),
		.tx_byte_i   (tx_byte),
		.tx_done_o   (tx_done),
		.rx_valid_o  (rx_valid),
		.rx_byte_o   (rx_byte)
	);

	// ***************************************
	// decode
	// ***************************************
	wire        settled    = (settle_cnt == SETTLE_CYCLES);
	wire        want_ser   = mode_sel_s & boot_ent_s;
	wire        want_par   = mode_sel_s & ~boot_ent_s;
	wire [15:0] ser_addr   = {arg[0], arg[1]};
	wire        ser_boot   = (ser_addr >= BOOT_START);
	wire        par_boot   = (par_addr_i >= BOOT_START);
	wire        is_id      = (rx_byte == CMD_ID);
	wire        is_prog    = (rx_byte == CMD_PROG);
	wire        known      = is_id | is_prog | (rx_byte == CMD_READ) | (rx_byte == CMD_ERASE);
	wire [2:0]  arg_need   = (cmd == CMD_ID) ? ARGS_ID : (cmd == CMD_PROG) ? ARGS_PROG : ARGS_ADDR;
	wire        last_arg   = rx_valid & (arg_cnt == arg_need - 3'h1);
	wire        ser_write  = (cmd == CMD_PROG) | (cmd == CMD_ERASE);
	wire [1:0]  ser_op     = (cmd == CMD_READ) ? OP_READ : (cmd == CMD_PROG) ? OP_PROG : OP_ERASE;
	wire        allowed    = id_ok_o | flash_blank_i;
	wire        ser_refuse = ~allowed | (ser_write & ser_boot);
	wire        id_match   = (flash_rdata_i == arg[id_idx]);
	wire [15:0] par_fa     = (par_op_i == OP_ERASE && par_boot) ? BOOT_END : par_addr_i;

	// argument bytes are data only, no reset needed
	always_ff @(posedge ref_clk_i)
	begin
		if (state == ST_ARG && rx_valid)
			arg[arg_cnt] <= rx_byte;
	end

	// ***************************************
	// mode entry and command sequencing
	// ***************************************
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state <= ST_SETTLE;
			settle_cnt <= 3'h0;
			par_mode_o <= 1'b0;
			ser_mode_o <= 1'b0;
			async_mode_o <= 1'b0;
			serial_transmit_port_bit_oe_o <= 1'b0;
			id_ok_o <= 1'b0;
			boot_touched_o <= 1'b0;
			busy_port_bit_o <= 1'b0;
			par_done_o <= 1'b0;
			par_err_o <= 1'b0;
			par_rdata_o <= 8'h00;
			flash_req_o <= 1'b0;
			flash_op_o <= OP_READ;
			flash_addr_o <= 16'h0000;
			flash_wdata_o <= 8'h00;
			cmd <= 8'h00;
			arg_cnt <= 3'h0;
			id_idx <= 3'h0;
			id_miss <= 1'b0;
			tx_valid <= 1'b0;
			tx_byte <= 8'h00;
		end
		else
		begin
			par_done_o <= 1'b0;
			tx_valid <= 1'b0;
			unique case (state)
				ST_SETTLE:
				begin
					settle_cnt <= settled ? settle_cnt : settle_cnt + 3'h1;
					if (settled)
						state <= (want_ser && flash_boot_intact_i) ? ST_CMD : ST_IDLE;
					ser_mode_o <= settled & want_ser & flash_boot_intact_i;
					serial_transmit_port_bit_oe_o <= settled & want_ser & flash_boot_intact_i;
					async_mode_o <= settled & ~sclk_s;
					par_mode_o <= settled & want_par;
				end
				ST_IDLE:
				begin
					if (par_mode_o && par_req_i)
					begin
						par_err_o <= (par_op_i == OP_BAD);
						par_done_o <= (par_op_i == OP_BAD);
						flash_req_o <= (par_op_i != OP_BAD);
						flash_op_o <= par_op_i;
						flash_addr_o <= par_fa;
						flash_wdata_o <= par_wdata_i;
						if (par_op_i != OP_BAD && par_op_i != OP_READ && par_boot)
							boot_touched_o <= 1'b1;
						if (par_op_i != OP_BAD)
							state <= ST_PAR_FLASH;
					end
				end
				ST_PAR_FLASH:
				begin
					if (flash_ack_i)
					begin
						flash_req_o <= 1'b0;
						par_done_o <= 1'b1;
						par_rdata_o <= flash_rdata_i;
						state <= ST_IDLE;
					end
				end
				ST_CMD:
				begin
					if (rx_valid && known)
					begin
						cmd <= rx_byte;
						arg_cnt <= 3'h0;
						state <= ST_ARG;
					end
				end
				ST_ARG:
				begin
					if (rx_valid)
						arg_cnt <= arg_cnt + 3'h1;
					if (last_arg)
					begin
						busy_port_bit_o <= 1'b1;
						state <= ST_EXEC;
					end
				end
				ST_EXEC:
				begin
					if (cmd == CMD_ID)
					begin
						id_idx <= 3'h0;
						id_miss <= 1'b0;
						flash_req_o <= 1'b1;
						flash_op_o <= OP_READ;
						flash_addr_o <= ID_FIRST;
						state <= ST_IDREAD;
					end
					else if (ser_refuse)
					begin
						busy_port_bit_o <= 1'b0;
						state <= ST_CMD;
					end
					else
					begin
						flash_req_o <= 1'b1;
						flash_op_o <= ser_op;
						flash_addr_o <= ser_addr;
						flash_wdata_o <= arg[2];
						state <= ST_SER_FLASH;
					end
				end
				ST_IDREAD:
				begin
					if (flash_ack_i && id_idx == ID_LAST_IX)
					begin
						flash_req_o <= 1'b0;
						id_ok_o <= ~id_miss & id_match;
						busy_port_bit_o <= 1'b0;
						state <= ST_CMD;
					end
					else if (flash_ack_i)
					begin
						id_miss <= id_miss | ~id_match;
						id_idx <= id_idx + 3'h1;
						flash_addr_o <= flash_addr_o + 16'h0001;
					end
				end
				ST_SER_FLASH:
				begin
					if (flash_ack_i)
					begin
						flash_req_o <= 1'b0;
						tx_valid <= (cmd == CMD_READ);
						tx_byte <= flash_rdata_i;
						busy_port_bit_o <= (cmd == CMD_READ);
						state <= (cmd == CMD_READ) ? ST_SEND : ST_CMD;
					end
				end
				ST_SEND:
				begin
					if (tx_done)
					begin
						busy_port_bit_o <= 1'b0;
						state <= ST_CMD;
					end
				end
			endcase
		end
	end

	// ***************************************
	// assertions
	// ***************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_id_enter;
		(state != ST_IDREAD) ##1 (state == ST_IDREAD);
	endsequence

	sequence s_ser_start;
		(state == ST_EXEC) ##1 (state == ST_SER_FLASH);
	endsequence

	a_boot_write_block: assert property (ser_mode_o && flash_req_o && flash_op_o != OP_READ
		|-> flash_addr_o < BOOT_START)
		else $error("serial write reached boot area");

	a_boot_erase_one: assert property (flash_req_o && flash_op_o == OP_ERASE
		&& flash_addr_o >= BOOT_START |-> flash_addr_o == BOOT_END)
		else $error("boot erase not issued as one block");

	a_id_gate_cmd: assert property (s_ser_start |-> $past(allowed, 2))
		else $error("command accepted without id match");

	a_id_first_addr: assert property (s_id_enter |-> flash_req_o && flash_addr_o == ID_FIRST)
		else $error("id read does not start at first id byte");

	a_id_addr_span: assert property (state == ST_IDREAD && flash_req_o
		|-> flash_addr_o >= ID_FIRST && flash_addr_o <= ID_LAST)
		else $error("id read outside id span");

	a_id_len_seven: assert property ($rose(id_ok_o) |-> $past(id_idx) == ID_LAST_IX)
		else $error("id check not seven bytes");

	a_entry_straps: assert property ($rose(ser_mode_o)
		|-> $past(mode_sel_s) && $past(boot_ent_s) && $past(flash_boot_intact_i))
		else $error("serial mode entered without straps");

	a_ser_pin_drive: assert property (ser_mode_o && state != ST_SEND
		|-> serial_transmit_port_bit_oe_o && serial_transmit_port_bit_o)
		else $error("transmit pin not driven idle high in serial mode");

	a_busy_in_work: assert property (s_ser_start |-> busy_port_bit_o [*2])
		else $error("busy low during command work");

	a_par_only: assert property (par_done_o |-> par_mode_o && !ser_mode_o)
		else $error("parallel answer outside parallel mode");

endmodule
`default_nettype wire
